// *** hdl/epc_defines.vh ***
// Command, status, reset and layout constants of the parameter channel interpreter
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH

// ****************************************
// Command bytes
// ****************************************
`define EPC_CMD_READ      8'h4a
`define EPC_CMD_STORE     8'h4b
`define EPC_CMD_FSTAT     8'h4c
`define EPC_CMD_CREATE    8'h4d
`define EPC_CMD_FREE      8'h4e
`define EPC_CMD_KEYCH     8'h4f
`define EPC_CMD_STATUS    8'h50
`define EPC_CMD_TYPE      8'h52
`define EPC_CMD_RESET     8'h53
`define EPC_CMD_ADDR      8'h55
`define EPC_CMD_SERIAL    8'h56
`define EPC_CMD_CONF      8'h57

// ****************************************
// Status codes
// ****************************************
`define EPC_ST_OK         8'h00
`define EPC_ST_TABLE      8'h03
`define EPC_ST_ICSUM      8'h06
`define EPC_ST_WDOG       8'h07
`define EPC_ST_CHKSUM     8'h0a
`define EPC_ST_UNKNOWN    8'h0b
`define EPC_ST_LEN        8'h0c
`define EPC_ST_RANGE      8'h0d
`define EPC_ST_PROT       8'h0e
`define EPC_ST_KEY        8'h0f
`define EPC_ST_FIXED      8'h10
`define EPC_ST_WORD       8'h11
`define EPC_ST_NOFIELD    8'h12
`define EPC_ST_EMITTER    8'h1d
`define EPC_ST_TEMP       8'h1e
`define EPC_ST_SPEED      8'h1f
`define EPC_ST_SINGLE     8'h20

// ****************************************
// Reset values and layout
// ****************************************
`define EPC_RST_KEY       8'h55
`define EPC_RST_ADDR      8'h40
`define EPC_RST_MODE      8'he4
`define EPC_MAX_ADDR      8'h7f
`define EPC_ERR_FLAG      8'h80
`define EPC_ARGS_NONE     4'hf
`define EPC_ATTR_PROT     0
`define EPC_ATTR_FIXED    1
`define EPC_FAULT_BITS    6

`endif

// *** hdl/epc_sync.v ***
// Two flip-flop synchroniser for a group of independent level inputs
`timescale 1ns/1ns
module epc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  assign q = sync_reg;

endmodule // epc_sync

// *** hdl/epc_field_store.v ***
// Data field store: byte words, per field size and attributes, free space
`timescale 1ns/1ns
`include "epc_defines.vh"
module epc_field_store #(
  parameter FIELD_BITS = 2,
  parameter WORD_BITS  = 4
) (
  input  wire                  clk,
  input  wire                  rst,
  input  wire [FIELD_BITS-1:0] field,
  input  wire [WORD_BITS-1:0]  word,
  input  wire                  wr_en,
  input  wire [7:0]            wr_data,
  output reg  [7:0]            rd_data,
  input  wire                  create_en,
  input  wire [WORD_BITS:0]    create_size,
  input  wire [1:0]            create_attr,
  output wire                  f_created,
  output wire [WORD_BITS:0]    f_size,
  output wire                  f_fixed,
  output wire                  f_prot,
  output reg  [7:0]            free_words
);

  localparam NFIELD = 1 << FIELD_BITS;
  localparam NWORDS = 1 << WORD_BITS;

  reg [7:0]         mem [0:NFIELD*NWORDS-1];
  reg [NFIELD-1:0]  created_reg;
  reg [NFIELD-1:0]  fixed_reg;
  reg [NFIELD-1:0]  prot_reg;
  reg [WORD_BITS:0] size_reg [0:NFIELD-1];
  integer           k;

  assign f_created = created_reg[field];
  assign f_size    = size_reg[field];
  assign f_fixed   = fixed_reg[field];
  assign f_prot    = prot_reg[field];

  // Memory has no reset so it can map onto block RAM
  always @(posedge clk) begin
    if (wr_en) begin
      mem[{field, word}] <= wr_data;
    end
    rd_data <= mem[{field, word}];
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      created_reg <= {NFIELD{1'b0}};
      fixed_reg   <= {NFIELD{1'b0}};
      prot_reg    <= {NFIELD{1'b0}};
      for (k = 0; k < NFIELD; k = k + 1) begin
        size_reg[k] <= {(WORD_BITS+1){1'b0}};
      end
    end else if (create_en) begin
      created_reg[field] <= 1'b1;
      fixed_reg[field]   <= create_attr[`EPC_ATTR_FIXED];
      prot_reg[field]    <= create_attr[`EPC_ATTR_PROT];
      size_reg[field]    <= create_size;
    end
  end

  always @* begin
    free_words = 8'd1 << (FIELD_BITS + WORD_BITS);
    for (k = 0; k < NFIELD; k = k + 1) begin
      free_words = free_words - {{(7-WORD_BITS){1'b0}}, size_reg[k]};
    end
  end

endmodule // epc_field_store

// *** hdl/epc_cmd_top.v ***
// Parameter channel command interpreter of the motor feedback encoder
// Behaviour
// - Half-duplex link, driver enabled only while replying
// - Decode data field read/store/status/create/free commands
// - Command 56h returns serial number and version
// - Command 55h assigns a new bus address
// - Command 57h changes serial line settings
// - Vital-parameter commands carry a checked key byte
// - Key byte holds 55h after reset
// - Status 00h when no fault found
// - Status 03h table corrupt, 06h checksum fail
// - Status 07h after watchdog caused reset
// - Status 0Ah on frame checksum mismatch
// - Status 0Bh on unimplemented command byte
// - Status 0Ch on wrong data byte count
// - Status 0Dh on argument out of range
// - Refuse protected field writes, status 0Eh
// - Status 0Fh when key does not match
// - Status 10h when resizing a fixed field
// - Status 11h when word beyond field end
// - Status 12h on access to missing field
// - Status 1Fh overspeed, 20h single-turn unreliable
// - Status 1Dh on critical emitter current
// - Status 1Eh on critical temperature
`timescale 1ns/1ns
`include "epc_defines.vh"
module epc_cmd_top #(
  parameter        FIELD_BITS = 2,
  parameter        WORD_BITS  = 4,
  parameter [31:0] SERIAL_NO  = 32'h0001_0203, // Arbitrary value
  parameter [7:0]  FW_VERSION = 8'h10,         // Arbitrary value
  parameter [7:0]  TYPE_ID    = 8'h3c          // Arbitrary value
) (
  input  wire       clk,
  input  wire       rst,
  input  wire [7:0] rx_byte,
  input  wire       rx_valid,
  input  wire       rx_end,
  output reg  [7:0] tx_byte_reg,
  output reg        tx_valid_reg,
  input  wire       tx_ready,
  output reg        line_drive_en_reg,
  output reg        busy_reg,
  output reg  [7:0] fault_code_reg,
  output reg  [7:0] bus_addr_reg,
  output reg  [7:0] line_mode_reg,
  output reg        soft_reset_reg,
  input  wire       table_bad_in,
  input  wire       int_csum_bad_in,
  input  wire       overspeed_in,
  input  wire       single_bad_in,
  input  wire       emitter_crit_in,
  input  wire       temp_crit_in,
  input  wire       wdog_cause_in
);

  localparam NFIELD = 1 << FIELD_BITS;
  localparam NWORDS = 1 << WORD_BITS;
  localparam [7:0] NFIELD_B = NFIELD;
  localparam [7:0] NWORDS_B = NWORDS;

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_EXEC  = 3'd1;
  localparam [2:0] S_MEM   = 3'd2;
  localparam [2:0] S_START = 3'd3;
  localparam [2:0] S_SEND  = 3'd4;

  // ****************************************
  // Expected argument count per command
  // ****************************************
  function [3:0] epc_arg_count;
    input [7:0] c;
    begin
      case (c)
        `EPC_CMD_READ:   epc_arg_count = 4'd2;
        `EPC_CMD_STORE:  epc_arg_count = 4'd4;
        `EPC_CMD_FSTAT:  epc_arg_count = 4'd1;
        `EPC_CMD_CREATE: epc_arg_count = 4'd4;
        `EPC_CMD_FREE:   epc_arg_count = 4'd0;
        `EPC_CMD_KEYCH:  epc_arg_count = 4'd2;
        `EPC_CMD_STATUS: epc_arg_count = 4'd0;
        `EPC_CMD_TYPE:   epc_arg_count = 4'd0;
        `EPC_CMD_RESET:  epc_arg_count = 4'd0;
        `EPC_CMD_ADDR:   epc_arg_count = 4'd2;
        `EPC_CMD_SERIAL: epc_arg_count = 4'd0;
        `EPC_CMD_CONF:   epc_arg_count = 4'd2;
        default:         epc_arg_count = `EPC_ARGS_NONE;
      endcase
    end
  endfunction

  reg  [2:0] state_reg;
  reg  [7:0] rx_buf [0:7];
  reg  [3:0] rx_cnt_reg;
  reg  [7:0] rx_xor_reg;
  reg        rx_ovf_reg;
  reg  [7:0] rep [0:7];
  reg  [3:0] rep_len_reg;
  reg  [3:0] tx_idx_reg;
  reg  [7:0] tx_xor_reg;
  reg  [7:0] key_reg;
  reg        wr_en_reg;
  reg        create_en_reg;
  reg  [1:0] boot_cnt_reg;
  reg        wdog_seen_reg;
  reg  [7:0] err_c;
  reg  [7:0] sensor_c;
  reg  [3:0] exp_n;

  wire [7:0] cmd     = rx_buf[1];
  wire [7:0] arg0    = rx_buf[2];
  wire [7:0] arg1    = rx_buf[3];
  wire [7:0] arg2    = rx_buf[4];
  wire [3:0] nargs   = rx_cnt_reg - 4'd3;
  wire [7:0] key_arg = rx_buf[rx_cnt_reg[2:0] - 3'd2];
  wire       key_bad = key_arg != key_reg;
  wire [5:0] flt;
  wire [7:0] rd_data;
  wire       f_created;
  wire [WORD_BITS:0] f_size;
  wire       f_fixed;
  wire       f_prot;
  wire [7:0] free_words;
  wire       wdog_sync;

  // ****************************************
  // Synchronised fault pins
  // ****************************************
  epc_sync #(.WIDTH(`EPC_FAULT_BITS + 1)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({wdog_cause_in, temp_crit_in, emitter_crit_in, single_bad_in,
           overspeed_in, int_csum_bad_in, table_bad_in}),
    .q   ({wdog_sync, flt})
  );

  epc_field_store #(.FIELD_BITS(FIELD_BITS), .WORD_BITS(WORD_BITS)) u_store (
    .clk         (clk),
    .rst         (rst),
    .field       (arg0[FIELD_BITS-1:0]),
    .word        (arg1[WORD_BITS-1:0]),
    .wr_en       (wr_en_reg),
    .wr_data     (arg2),
    .rd_data     (rd_data),
    .create_en   (create_en_reg),
    .create_size (arg1[WORD_BITS:0]),
    .create_attr (arg2[1:0]),
    .f_created   (f_created),
    .f_size      (f_size),
    .f_fixed     (f_fixed),
    .f_prot      (f_prot),
    .free_words  (free_words)
  );

  // ****************************************
  // Sensor fault priority, highest first
  // ****************************************
  always @* begin
    sensor_c = `EPC_ST_OK;
    if (flt[0]) sensor_c = `EPC_ST_TABLE;
    else if (flt[1]) sensor_c = `EPC_ST_ICSUM;
    else if (flt[2]) sensor_c = `EPC_ST_SPEED;
    else if (flt[3]) sensor_c = `EPC_ST_SINGLE;
    else if (flt[4]) sensor_c = `EPC_ST_EMITTER;
    else if (flt[5]) sensor_c = `EPC_ST_TEMP;
  end

  // ****************************************
  // Frame check, first failing test wins
  // ****************************************
  always @* begin
    err_c = `EPC_ST_OK;
    exp_n = epc_arg_count(cmd);
    if (rx_xor_reg != 8'h00) begin
      err_c = `EPC_ST_CHKSUM;
    end else if (exp_n == `EPC_ARGS_NONE) begin
      err_c = `EPC_ST_UNKNOWN;
    end else if (rx_ovf_reg || nargs != exp_n) begin
      err_c = `EPC_ST_LEN;
    end else begin
      case (cmd)
        `EPC_CMD_READ: begin
          if (arg0 >= NFIELD_B) err_c = `EPC_ST_RANGE;
          else if (!f_created) err_c = `EPC_ST_NOFIELD;
          else if ({3'h0, arg1[WORD_BITS:0]} >= {3'h0, f_size} || arg1 >= NWORDS_B)
            err_c = `EPC_ST_WORD;
        end
        `EPC_CMD_STORE: begin
          if (arg0 >= NFIELD_B) err_c = `EPC_ST_RANGE;
          else if (key_bad) err_c = `EPC_ST_KEY;
          else if (!f_created) err_c = `EPC_ST_NOFIELD;
          else if (f_prot) err_c = `EPC_ST_PROT;
          else if ({3'h0, arg1[WORD_BITS:0]} >= {3'h0, f_size} || arg1 >= NWORDS_B)
            err_c = `EPC_ST_WORD;
        end
        `EPC_CMD_FSTAT: begin
          if (arg0 >= NFIELD_B) err_c = `EPC_ST_RANGE;
          else if (!f_created) err_c = `EPC_ST_NOFIELD;
        end
        `EPC_CMD_CREATE: begin
          if (arg0 >= NFIELD_B || arg1 == 8'h00 || arg1 > NWORDS_B)
            err_c = `EPC_ST_RANGE;
          else if (key_bad) err_c = `EPC_ST_KEY;
          else if (f_created && f_fixed) err_c = `EPC_ST_FIXED;
        end
        `EPC_CMD_ADDR: begin
          if (arg0 > `EPC_MAX_ADDR) err_c = `EPC_ST_RANGE;
          else if (key_bad) err_c = `EPC_ST_KEY;
        end
        `EPC_CMD_CONF: begin
          if (key_bad) err_c = `EPC_ST_KEY;
        end
        `EPC_CMD_KEYCH: begin
          if (arg0 != key_reg) err_c = `EPC_ST_KEY;
        end
        default: err_c = `EPC_ST_OK;
      endcase
    end
  end

  // ****************************************
  // Receive, execute and reply
  // ****************************************
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg         <= S_IDLE;
      rx_cnt_reg        <= 4'h0;
      rx_xor_reg        <= 8'h00;
      rx_ovf_reg        <= 1'b0;
      rep_len_reg       <= 4'h0;
      tx_idx_reg        <= 4'h0;
      tx_xor_reg        <= 8'h00;
      tx_byte_reg       <= 8'h00;
      tx_valid_reg      <= 1'b0;
      line_drive_en_reg <= 1'b0;
      busy_reg          <= 1'b0;
      fault_code_reg    <= `EPC_ST_OK;
      bus_addr_reg      <= `EPC_RST_ADDR;
      line_mode_reg     <= `EPC_RST_MODE;
      key_reg           <= `EPC_RST_KEY;
      soft_reset_reg    <= 1'b0;
      wr_en_reg         <= 1'b0;
      create_en_reg     <= 1'b0;
      boot_cnt_reg      <= 2'd0;
      wdog_seen_reg     <= 1'b0;
    end else begin
      wr_en_reg      <= 1'b0;
      create_en_reg  <= 1'b0;
      soft_reset_reg <= 1'b0;
      // Watchdog cause is a strap, caught once the synchroniser has settled
      if (boot_cnt_reg != 2'd3) begin
        boot_cnt_reg <= boot_cnt_reg + 2'd1;
      end else if (!wdog_seen_reg) begin
        wdog_seen_reg <= 1'b1;
        if (wdog_sync) fault_code_reg <= `EPC_ST_WDOG;
      end
      case (state_reg)
        S_IDLE: begin
          if (rx_valid) begin
            if (rx_cnt_reg[3]) begin
              rx_ovf_reg <= 1'b1;
            end else begin
              rx_buf[rx_cnt_reg[2:0]] <= rx_byte;
              rx_cnt_reg <= rx_cnt_reg + 4'h1;
            end
            rx_xor_reg <= rx_xor_reg ^ rx_byte;
          end else if (rx_end) begin
            // Frames for other addresses or too short to name a command are dropped
            if (rx_cnt_reg >= 4'd2 && rx_buf[0] == bus_addr_reg) begin
              state_reg <= S_EXEC;
              busy_reg  <= 1'b1;
            end else begin
              rx_cnt_reg <= 4'h0;
              rx_xor_reg <= 8'h00;
              rx_ovf_reg <= 1'b0;
            end
          end
        end
        S_EXEC: begin
          rep[0]      <= bus_addr_reg;
          rep[1]      <= cmd;
          rep_len_reg <= 4'd2;
          state_reg   <= S_START;
          if (err_c != `EPC_ST_OK) begin
            // A failed command, guarded ones included, changes nothing but the code
            rep[1]         <= cmd | `EPC_ERR_FLAG;
            rep[2]         <= err_c;
            rep_len_reg    <= 4'd3;
            fault_code_reg <= err_c;
          end else begin
            case (cmd)
              `EPC_CMD_READ: begin
                rep_len_reg <= 4'd3;
                state_reg   <= S_MEM;
              end
              `EPC_CMD_STORE: wr_en_reg <= 1'b1;
              `EPC_CMD_FSTAT: begin
                rep[2]      <= {6'h00, f_fixed, f_prot};
                rep[3]      <= {3'h0, f_size};
                rep_len_reg <= 4'd4;
              end
              `EPC_CMD_CREATE: create_en_reg <= 1'b1;
              `EPC_CMD_FREE: begin
                rep[2]      <= free_words;
                rep_len_reg <= 4'd3;
              end
              `EPC_CMD_KEYCH: key_reg <= arg1;
              `EPC_CMD_STATUS: begin
                rep[2]         <= fault_code_reg;
                rep_len_reg    <= 4'd3;
                fault_code_reg <= `EPC_ST_OK;
              end
              `EPC_CMD_TYPE: begin
                rep[2]      <= TYPE_ID;
                rep_len_reg <= 4'd3;
              end
              `EPC_CMD_RESET: begin
                fault_code_reg <= `EPC_ST_OK;
                soft_reset_reg <= 1'b1;
              end
              `EPC_CMD_ADDR: begin
                bus_addr_reg <= arg0;
                rep[0]       <= arg0;
              end
              `EPC_CMD_SERIAL: begin
                rep[2]      <= SERIAL_NO[31:24];
                rep[3]      <= SERIAL_NO[23:16];
                rep[4]      <= SERIAL_NO[15:8];
                rep[5]      <= SERIAL_NO[7:0];
                rep[6]      <= FW_VERSION;
                rep_len_reg <= 4'd7;
              end
              `EPC_CMD_CONF: line_mode_reg <= arg0;
              default: rep_len_reg <= 4'd2;
            endcase
          end
        end
        S_MEM: begin
          rep[2]    <= rd_data;
          state_reg <= S_START;
        end
        S_START: begin
          tx_byte_reg       <= rep[0];
          tx_xor_reg        <= rep[0];
          tx_idx_reg        <= 4'd1;
          tx_valid_reg      <= 1'b1;
          line_drive_en_reg <= 1'b1;
          state_reg         <= S_SEND;
        end
        S_SEND: begin
          if (tx_ready) begin
            if (tx_idx_reg < rep_len_reg) begin
              tx_byte_reg <= rep[tx_idx_reg[2:0]];
              tx_xor_reg  <= tx_xor_reg ^ rep[tx_idx_reg[2:0]];
              tx_idx_reg  <= tx_idx_reg + 4'd1;
            end else if (tx_idx_reg == rep_len_reg) begin
              tx_byte_reg <= tx_xor_reg;
              tx_idx_reg  <= tx_idx_reg + 4'd1;
            end else begin
              // Driver released right after the checksum byte
              tx_valid_reg      <= 1'b0;
              line_drive_en_reg <= 1'b0;
              busy_reg          <= 1'b0;
              rx_cnt_reg        <= 4'h0;
              rx_xor_reg        <= 8'h00;
              rx_ovf_reg        <= 1'b0;
              state_reg         <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
      // Live sensor faults override any other update of the code
      if (sensor_c != `EPC_ST_OK) begin
        fault_code_reg <= sensor_c;
      end
    end
  end

endmodule // epc_cmd_top

// *** dv/epc_cmd_props.sv ***
// Port-level checks of the parameter channel command interpreter
`timescale 1ns/1ns
module epc_cmd_props (
  input logic       clk,
  input logic       rst,
  input logic       rx_end,
  input logic [7:0] tx_byte_reg,
  input logic       tx_valid_reg,
  input logic       tx_ready,
  input logic       line_drive_en_reg,
  input logic       busy_reg,
  input logic [7:0] fault_code_reg,
  input logic [7:0] bus_addr_reg,
  input logic [7:0] line_mode_reg,
  input logic       table_bad_in,
  input logic       int_csum_bad_in,
  input logic       overspeed_in,
  input logic       single_bad_in,
  input logic       emitter_crit_in,
  input logic       temp_crit_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Sequences
  // ****************************************
  // Four cycles cover the two-flop sync plus the status register
  sequence table_seq;
    table_bad_in [*4];
  endsequence
  sequence speed_seq;
    (overspeed_in && !table_bad_in && !int_csum_bad_in) [*4];
  endsequence
  sequence temp_seq;
    (temp_crit_in && !table_bad_in && !int_csum_bad_in && !overspeed_in && !single_bad_in
     && !emitter_crit_in) [*4];
  endsequence
  sequence frame_taken;
    rx_end ##1 $rose(busy_reg);
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  busy_cause_a:
    assert property ($rose(busy_reg) |-> $past(rx_end)) else $error("busy without frame end");
  reply_delay_a:
    assert property (frame_taken |-> ##[2:3] $rose(tx_valid_reg))
      else $error("reply start late");
  drive_cover_a:
    assert property (tx_valid_reg |-> line_drive_en_reg && busy_reg)
      else $error("reply byte without driver");
  tx_hold_a:
    assert property (tx_valid_reg && !tx_ready |=> tx_valid_reg && $stable(tx_byte_reg))
      else $error("reply byte changed unaccepted");
  first_addr_a:
    assert property ($rose(tx_valid_reg) |-> tx_byte_reg == bus_addr_reg)
      else $error("reply address wrong");
  reply_end_a:
    assert property ($fell(tx_valid_reg) |-> !busy_reg && !line_drive_en_reg)
      else $error("driver left on");
  mode_busy_a:
    assert property ($changed(line_mode_reg) |-> busy_reg || $past(busy_reg))
      else $error("line mode changed idle");
  addr_busy_a:
    assert property ($changed(bus_addr_reg) |-> busy_reg || $past(busy_reg))
      else $error("address changed idle");
  table_code_a:
    assert property (table_seq |-> fault_code_reg == 8'h03) else $error("table code");
  speed_code_a:
    assert property (speed_seq |-> fault_code_reg == 8'h1f) else $error("speed code");
  temp_code_a:
    assert property (temp_seq |-> fault_code_reg == 8'h1e) else $error("temperature code");
endmodule // epc_cmd_props

bind epc_cmd_top epc_cmd_props epc_cmd_props_inst (
  .clk(clk), .rst(rst), .rx_end(rx_end), .tx_byte_reg(tx_byte_reg),
  .tx_valid_reg(tx_valid_reg), .tx_ready(tx_ready), .line_drive_en_reg(line_drive_en_reg),
  .busy_reg(busy_reg), .fault_code_reg(fault_code_reg), .bus_addr_reg(bus_addr_reg),
  .line_mode_reg(line_mode_reg), .table_bad_in(table_bad_in),
  .int_csum_bad_in(int_csum_bad_in), .overspeed_in(overspeed_in),
  .single_bad_in(single_bad_in), .emitter_crit_in(emitter_crit_in),
  .temp_crit_in(temp_crit_in)
);

// *** dv/epc_host_model.sv ***
// Drive controller model: sends one frame, then takes the reply
`timescale 1ns/1ns
module epc_host_model (
  input  logic       clk,
  input  logic [7:0] tx_byte,
  input  logic       tx_valid,
  input  logic       busy,
  output logic [7:0] rx_byte,
  output logic       rx_valid,
  output logic       rx_end,
  output logic       tx_ready
);
  logic [7:0] rep [0:15];
  int         rep_n;
  bit         tmo;
  initial begin
    rx_byte  = 8'h00;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
    tx_ready = 1'b0;
  end
  // Half duplex: nothing goes out until the reply has ended
  task automatic send(input logic [7:0] f [8], input int n, input bit slow);
    int k;
    bit seen;
    seen  = 0;
    rep_n = 0;
    tmo   = 1;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      rx_byte  <= f[k];
      rx_valid <= 1'b1;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_end   <= 1'b1;
    // Released line must not keep the last byte
    rx_byte  <= ~f[n-1];
    @(posedge clk);
    rx_end <= 1'b0;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (tx_valid && tx_ready && rep_n < 16) begin
        rep[rep_n] = tx_byte;
        rep_n++;
      end
      seen = seen | busy;
      if ((seen && !busy) || (!seen && k > 8)) begin
        tmo = 0;
        break;
      end
      tx_ready <= slow ? (k % 3 == 2) : 1'b1;
    end
    tx_ready <= 1'b0;
  endtask
endmodule // epc_host_model

// *** dv/epc_cmd_top_tb_top.sv ***
// Self-checking bench of the parameter channel command interpreter
`timescale 1ns/1ns
module epc_cmd_top_tb_top;
  localparam logic [31:0] SER = 32'h0a0b_0c0d; // Arbitrary value
  localparam logic [7:0]  FW  = 8'h21;         // Arbitrary value
  localparam logic [7:0]  TID = 8'h5a;         // Arbitrary value
  typedef struct {
    logic [7:0]  c;
    logic [31:0] args;
    int          na;
    logic        err;
    logic [63:0] rd;
    int          nr;
  } epc_row_t;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic [5:0] sens = 6'h00;
  logic       wdog = 1'b0;
  wire  [7:0] rx_byte, tx_byte, fault, bus_addr, line_mode;
  wire        rx_valid, rx_end, tx_valid, tx_ready, busy, srst;
  int         n_mismatch  = 0;
  int         comparisons = 0;
  int         r;
  int         n_srst = 0;
  epc_row_t   rows [0:22];
  logic [7:0] codes [0:5] = '{8'h03, 8'h06, 8'h1f, 8'h20, 8'h1d, 8'h1e};
  always #5 clk = ~clk;
  always @(posedge clk) if (srst) n_srst++;
  epc_cmd_top #(.SERIAL_NO(SER), .FW_VERSION(FW), .TYPE_ID(TID)) epc_cmd_top_inst (
    .clk(clk), .rst(rst), .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_end(rx_end),
    .tx_byte_reg(tx_byte), .tx_valid_reg(tx_valid), .tx_ready(tx_ready),
    .line_drive_en_reg(), .busy_reg(busy), .fault_code_reg(fault), .bus_addr_reg(bus_addr),
    .line_mode_reg(line_mode), .soft_reset_reg(srst), .table_bad_in(sens[0]),
    .int_csum_bad_in(sens[1]), .overspeed_in(sens[2]), .single_bad_in(sens[3]),
    .emitter_crit_in(sens[4]), .temp_crit_in(sens[5]), .wdog_cause_in(wdog));
  epc_host_model host_inst (
    .clk(clk), .tx_byte(tx_byte), .tx_valid(tx_valid), .busy(busy), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_end(rx_end), .tx_ready(tx_ready));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Frame checksum makes the XOR of all bytes zero; bad flips it on purpose
  task automatic run(input logic [7:0] a, c, input logic [31:0] args, input int na,
                     input logic [7:0] ra, rc, input logic [63:0] rd, input int nr,
                     input bit slow, input logic [7:0] bad);
    logic [7:0] f [8];
    logic [7:0] x;
    int         i;
    f = '{default: 8'h00};
    f[0] = a;
    f[1] = c;
    for (i = 0; i < na; i++) f[2+i] = args[8*(na-1-i) +: 8];
    x = 8'h00;
    for (i = 0; i < na + 2; i++) x ^= f[i];
    f[na+2] = x ^ bad;
    host_inst.send(f, na + 3, slow);
    if (host_inst.tmo) begin
      n_mismatch++;
      finish_test();
    end
    chk(host_inst.rep_n, (nr < 0) ? 0 : nr + 3);
    if (nr >= 0 && host_inst.rep_n == nr + 3) begin
      chk(host_inst.rep[0], ra);
      chk(host_inst.rep[1], rc);
      x = ra ^ rc;
      for (i = 0; i < nr; i++) begin
        chk(host_inst.rep[2+i], rd[8*(nr-1-i) +: 8]);
        x ^= rd[8*(nr-1-i) +: 8];
      end
      chk(host_inst.rep[nr+2], x);
    end
  endtask
  initial begin
    rows = '{
      '{8'h50, 32'h0, 0, 1'b0, 64'h00, 1},
      '{8'h4a, 32'h0000, 2, 1'b1, 64'h12, 1},
      '{8'h4d, 32'h0004_0055, 4, 1'b0, 64'h0, 0},
      '{8'h4b, 32'h0001_a555, 4, 1'b0, 64'h0, 0},
      '{8'h4a, 32'h0001, 2, 1'b0, 64'ha5, 1},
      '{8'h4a, 32'h0004, 2, 1'b1, 64'h11, 1},
      '{8'h4b, 32'h0001_3312, 4, 1'b1, 64'h0f, 1},
      '{8'h4a, 32'h0001, 2, 1'b0, 64'ha5, 1},
      '{8'h50, 32'h0, 0, 1'b0, 64'h0f, 1},
      '{8'h4d, 32'h0102_0355, 4, 1'b0, 64'h0, 0},
      '{8'h4b, 32'h0100_1155, 4, 1'b1, 64'h0e, 1},
      '{8'h4d, 32'h0103_0055, 4, 1'b1, 64'h10, 1},
      '{8'h4c, 32'h01, 1, 1'b0, 64'h0302, 2},
      '{8'h4e, 32'h0, 0, 1'b0, 64'h3a, 1},
      '{8'h52, 32'h0, 0, 1'b0, {56'h0, TID}, 1},
      '{8'h56, 32'h0, 0, 1'b0, {24'h0, SER, FW}, 5},
      '{8'h41, 32'h0, 0, 1'b1, 64'h0b, 1},
      '{8'h50, 32'h0, 4, 1'b1, 64'h0c, 1},
      '{8'h55, 32'h8055, 2, 1'b1, 64'h0d, 1},
      '{8'h53, 32'h0, 0, 1'b0, 64'h0, 0},
      '{8'h50, 32'h0, 0, 1'b0, 64'h00, 1},
      '{8'h57, 32'ha555, 2, 1'b0, 64'h0, 0},
      '{8'h57, 32'h0012, 2, 1'b1, 64'h0f, 1}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(bus_addr, 8'h40);
    chk(line_mode, 8'he4);
    chk(fault, 8'h00);
    for (r = 0; r < 23; r++)
      run(8'h40, rows[r].c, rows[r].args, rows[r].na, 8'h40, rows[r].c | {rows[r].err, 7'h00},
          rows[r].rd, rows[r].nr, r[0], 8'h00);
    chk(line_mode, 8'ha5);
    chk(n_srst, 1);
    run(8'h40, 8'h50, 0, 0, 8'h40, 8'hd0, 64'h0a, 1, 0, 8'h01);
    run(8'h40, 8'h55, 32'h2155, 2, 8'h21, 8'h55, 0, 0, 1, 0);
    run(8'h40, 8'h52, 0, 0, 0, 0, 0, -1, 0, 0);
    run(8'h21, 8'h4f, 32'h5577, 2, 8'h21, 8'h4f, 0, 0, 0, 0);
    run(8'h21, 8'h57, 32'h1155, 2, 8'h21, 8'hd7, 64'h0f, 1, 0, 0);
    run(8'h21, 8'h57, 32'h1177, 2, 8'h21, 8'h57, 0, 0, 1, 0);
    chk(line_mode, 8'h11);
    for (r = 0; r < 6; r++) begin
      sens <= 6'h01 << r;
      repeat (5) @(posedge clk);
      chk(fault, codes[r]);
    end
    sens <= 6'h3f;
    repeat (5) @(posedge clk);
    chk(fault, 8'h03);
    sens <= 6'h00;
    wdog <= 1'b1;
    rst  <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(bus_addr, 8'h40);
    chk(fault, 8'h07);
    run(8'h40, 8'h50, 0, 0, 8'h40, 8'h50, 64'h07, 1, 0, 0);
    run(8'h40, 8'h50, 0, 0, 8'h40, 8'h50, 64'h00, 1, 1, 0);
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule // epc_cmd_top_tb_top
